/* src/spimsp_pkg.sv */
// constants, types and helpers for the serial peripheral port
// assumes one register port on the system clock and one link clock from the pins
package spimsp_pkg;
  localparam logic [15:0] OFS_CONFIG_CONTROL = 16'h7040;
  localparam logic [15:0] OFS_OPERATION_CONTROL = 16'h7041;
  localparam logic [15:0] OFS_PORT_STATUS = 16'h7042;
  localparam logic [15:0] OFS_BIT_RATE_DIVISOR = 16'h7044;
  localparam logic [15:0] OFS_RECEIVE_BUFFER = 16'h7047;
  localparam logic [15:0] OFS_SHIFT_DATA = 16'h7049;
  localparam logic [15:0] OFS_PIN_CONTROL_ONE = 16'h704d;
  localparam logic [15:0] OFS_PIN_CONTROL_TWO = 16'h704e;
  localparam logic [15:0] OFS_PRIORITY_CONTROL = 16'h704f;
  localparam int CCR_LEN_LSB = 0;
  localparam int CCR_POL_BIT = 6;
  localparam int OCR_INTEN_BIT = 0;
  localparam int OCR_TRANSMIT_ENABLE_BIT_BIT = 1;
  localparam int OCR_MASTER_BIT = 2;
  localparam int OCR_PHA_BIT = 3;
  localparam int STS_RXAV_BIT = 0;
  localparam int STS_BUSY_BIT = 1;
  localparam int STS_OVR_BIT = 2;
  localparam int STS_TXP_BIT = 3;
  localparam int PC1_STEFN_BIT = 0;
  localparam int PRI_LOW_BIT = 6;
  localparam logic [7:0] RST_CONFIG_CONTROL = 8'h07;
  localparam logic [7:0] RST_OPERATION_CONTROL = 8'h00;
  localparam logic [7:0] RST_BIT_RATE_DIVISOR = 8'h03;
  localparam logic [7:0] RST_PIN_CONTROL = 8'h00;
  localparam logic [7:0] RST_PRIORITY_CONTROL = 8'h00;
  localparam int SYS_CLK_PERIOD_NS = 25;
  localparam int CHAR_W = 8;
  localparam int RX_FIFO_DEPTH = 16;

  typedef struct packed {
    logic [2:0] len_m1;
    logic pol;
    logic pha;
    logic master;
    logic transmit_enable_bit;
    logic int_en;
    logic ste_fn;
    logic lvl_low;
  } spimsp_cfg_t;

  typedef enum logic [1:0] {
    SPIMSP_M_IDLE = 2'b00,
    SPIMSP_M_RUN = 2'b01,
    SPIMSP_M_DONE = 2'b10
  } spimsp_mst_t;

  // left-align a character so its top bit leaves first
  function automatic logic [7:0] spimsp_align(input logic [7:0] d, input logic [2:0] len_m1);
    spimsp_align = d << (3'h7 - len_m1);
  endfunction : spimsp_align
endpackage : spimsp_pkg

/* src/spimsp_fifo.sv */
// receive character fifo with valid/ready on both sides
// assumes a single clock and synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module spimsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem[rd_ptr_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule : spimsp_fifo
`default_nettype wire

/* src/spimsp_top.sv */
// serial peripheral port, master or slave, with register port and rx fifo
// assumes registers accessed on CLK_SYS; slave logic clocked by the serial clock pin
`timescale 1ns/100ps
`default_nettype none
module spimsp_top (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic [15:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic SERIAL_BIT_CLOCK_PIN_I,
  output logic SERIAL_BIT_CLOCK_PIN_O,
  output logic SERIAL_BIT_CLOCK_PIN_OE_N,
  input wire logic SLAVE_IN_MASTER_OUT_LINE_I,
  output logic SLAVE_IN_MASTER_OUT_LINE_O,
  output logic SLAVE_IN_MASTER_OUT_LINE_OE_N,
  input wire logic SLAVE_OUT_MASTER_IN_LINE_I,
  output logic SLAVE_OUT_MASTER_IN_LINE_O,
  output logic SLAVE_OUT_MASTER_IN_LINE_OE_N,
  input wire logic SLAVE_ENABLE_PIN_N,
  output logic INT_HIGH_LEVEL,
  output logic INT_LOW_LEVEL
);
  logic [7:0] config_control_ff;
  logic [7:0] operation_control_ff;
  logic [7:0] bit_rate_divisor_ff;
  logic [7:0] pin_control_one_ff;
  logic [7:0] pin_control_two_ff;
  logic [7:0] priority_control_ff;
  logic [7:0] shift_data_ff;
  logic overrun_ff;
  logic go_ff;
  logic tx_tgl_ff;
  logic ste_s1_ff;
  logic ste_s2_ff;
  logic somi_s1_ff;
  logic somi_s2_ff;
  logic ack_s1_ff;
  logic ack_s2_ff;
  logic rxt_s1_ff;
  logic rxt_s2_ff;
  logic rxt_s3_ff;
  logic lclr_ff;
  logic lrst_ff;
  spimsp_pkg::spimsp_cfg_t cfg;
  spimsp_pkg::spimsp_mst_t mst_state_ff;
  logic [7:0] hc_ff;
  logic [3:0] ei_ff;
  logic [7:0] tsh_ff;
  logic [7:0] rsh_ff;
  logic wr_cc;
  logic wr_oc;
  logic wr_st;
  logic wr_br;
  logic wr_sd;
  logic wr_p1;
  logic wr_p2;
  logic wr_pr;
  logic rd_rb;
  logic tx_pending;
  logic slv_new;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_in_data;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic irq;
  logic half_end;
  logic lead_edge;
  logic lclk;
  logic [2:0] lcnt_ff;
  logic [7:0] lsh_ff;
  logic [7:0] lrs_ff;
  logic [7:0] lrx_word_ff;
  logic lrx_tgl_ff;
  logic ltx_s1_ff;
  logic ltx_s2_ff;
  logic lseen_ff;
  logic [7:0] lword_ff;
  logic lso_ff;
  logic [7:0] nxt_lrs;

  assign cfg.len_m1 = config_control_ff[spimsp_pkg::CCR_LEN_LSB +: 3];
  assign cfg.pol = config_control_ff[spimsp_pkg::CCR_POL_BIT];
  assign cfg.pha = operation_control_ff[spimsp_pkg::OCR_PHA_BIT];
  assign cfg.master = operation_control_ff[spimsp_pkg::OCR_MASTER_BIT];
  assign cfg.transmit_enable_bit = operation_control_ff[spimsp_pkg::OCR_TRANSMIT_ENABLE_BIT_BIT];
  assign cfg.int_en = operation_control_ff[spimsp_pkg::OCR_INTEN_BIT];
  assign cfg.ste_fn = pin_control_one_ff[spimsp_pkg::PC1_STEFN_BIT];
  assign cfg.lvl_low = priority_control_ff[spimsp_pkg::PRI_LOW_BIT];

  always_comb begin
    wr_cc = 1'b0;
    wr_oc = 1'b0;
    wr_st = 1'b0;
    wr_br = 1'b0;
    wr_sd = 1'b0;
    wr_p1 = 1'b0;
    wr_p2 = 1'b0;
    wr_pr = 1'b0;
    if (REG_ADDR == spimsp_pkg::OFS_CONFIG_CONTROL) begin
      wr_cc = REG_WR;
    end else if (REG_ADDR == spimsp_pkg::OFS_OPERATION_CONTROL) begin
      wr_oc = REG_WR;
    end else if (REG_ADDR == spimsp_pkg::OFS_PORT_STATUS) begin
      wr_st = REG_WR;
    end else if (REG_ADDR == spimsp_pkg::OFS_BIT_RATE_DIVISOR) begin
      wr_br = REG_WR;
    end else if (REG_ADDR == spimsp_pkg::OFS_SHIFT_DATA) begin
      wr_sd = REG_WR;
    end else if (REG_ADDR == spimsp_pkg::OFS_PIN_CONTROL_ONE) begin
      wr_p1 = REG_WR;
    end else if (REG_ADDR == spimsp_pkg::OFS_PIN_CONTROL_TWO) begin
      wr_p2 = REG_WR;
    end else if (REG_ADDR == spimsp_pkg::OFS_PRIORITY_CONTROL) begin
      wr_pr = REG_WR;
    end
  end
  assign rd_rb = REG_RD & (REG_ADDR == spimsp_pkg::OFS_RECEIVE_BUFFER);

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      config_control_ff <= spimsp_pkg::RST_CONFIG_CONTROL;
      operation_control_ff <= spimsp_pkg::RST_OPERATION_CONTROL;
      bit_rate_divisor_ff <= spimsp_pkg::RST_BIT_RATE_DIVISOR;
      pin_control_one_ff <= spimsp_pkg::RST_PIN_CONTROL;
      pin_control_two_ff <= spimsp_pkg::RST_PIN_CONTROL;
      priority_control_ff <= spimsp_pkg::RST_PRIORITY_CONTROL;
    end else begin
      if (wr_cc) begin
        config_control_ff <= REG_WDATA;
      end
      if (wr_oc) begin
        operation_control_ff <= REG_WDATA;
      end
      if (wr_br) begin
        bit_rate_divisor_ff <= REG_WDATA;
      end
      if (wr_p1) begin
        pin_control_one_ff <= REG_WDATA;
      end
      if (wr_p2) begin
        pin_control_two_ff <= REG_WDATA;
      end
      if (wr_pr) begin
        priority_control_ff <= REG_WDATA;
      end
    end
  end

  // transmit data and its handover
  assign tx_pending = tx_tgl_ff ^ ack_s2_ff;
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      shift_data_ff <= 8'h00;
      go_ff <= 1'b0;
      tx_tgl_ff <= 1'b0;
    end else begin
      if (wr_sd && cfg.master && !go_ff && mst_state_ff == spimsp_pkg::SPIMSP_M_IDLE) begin
        shift_data_ff <= REG_WDATA;
        go_ff <= 1'b1;
      end else if (wr_sd && !cfg.master && !tx_pending) begin
        shift_data_ff <= REG_WDATA;
        tx_tgl_ff <= ~tx_tgl_ff;
      end else if (go_ff && mst_state_ff == spimsp_pkg::SPIMSP_M_IDLE && fifo_in_ready) begin
        go_ff <= 1'b0;
      end
    end
  end

  // pin and cross-domain synchronisers
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      ste_s1_ff <= 1'b1;
      ste_s2_ff <= 1'b1;
      somi_s1_ff <= 1'b0;
      somi_s2_ff <= 1'b0;
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      rxt_s1_ff <= 1'b0;
      rxt_s2_ff <= 1'b0;
      rxt_s3_ff <= 1'b0;
    end else begin
      ste_s1_ff <= SLAVE_ENABLE_PIN_N;
      ste_s2_ff <= ste_s1_ff;
      somi_s1_ff <= SLAVE_OUT_MASTER_IN_LINE_I;
      somi_s2_ff <= somi_s1_ff;
      ack_s1_ff <= lseen_ff;
      ack_s2_ff <= ack_s1_ff;
      rxt_s1_ff <= lrx_tgl_ff;
      rxt_s2_ff <= rxt_s1_ff;
      rxt_s3_ff <= rxt_s2_ff;
    end
  end
  assign slv_new = rxt_s2_ff ^ rxt_s3_ff;

  // link shifter held clear in master mode, or while deselected with the enable pin function on
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      lclr_ff <= 1'b1;
      lrst_ff <= 1'b1;
    end else begin
      lclr_ff <= cfg.master | (cfg.ste_fn & ste_s2_ff);
      lrst_ff <= 1'b0;
    end
  end

  assign half_end = (hc_ff == bit_rate_divisor_ff);
  assign lead_edge = ~ei_ff[0];

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      mst_state_ff <= spimsp_pkg::SPIMSP_M_IDLE;
      hc_ff <= 8'h00;
      ei_ff <= 4'h0;
      tsh_ff <= 8'h00;
      rsh_ff <= 8'h00;
      SERIAL_BIT_CLOCK_PIN_O <= 1'b0;
      SLAVE_IN_MASTER_OUT_LINE_O <= 1'b0;
    end else begin
      case (mst_state_ff)
        spimsp_pkg::SPIMSP_M_IDLE: begin
          SERIAL_BIT_CLOCK_PIN_O <= cfg.pol;
          hc_ff <= 8'h00;
          ei_ff <= 4'h0;
          if (go_ff && fifo_in_ready) begin
            mst_state_ff <= spimsp_pkg::SPIMSP_M_RUN;
            rsh_ff <= 8'h00;
            // phase zero presents first bit early
            if (!cfg.pha) begin
              SLAVE_IN_MASTER_OUT_LINE_O <= shift_data_ff[cfg.len_m1];
              tsh_ff <= spimsp_pkg::spimsp_align(shift_data_ff, cfg.len_m1) << 1;
            end else begin
              tsh_ff <= spimsp_pkg::spimsp_align(shift_data_ff, cfg.len_m1);
            end
          end
        end
        spimsp_pkg::SPIMSP_M_RUN: begin
          if (half_end) begin
            hc_ff <= 8'h00;
            ei_ff <= ei_ff + 4'h1;
            SERIAL_BIT_CLOCK_PIN_O <= ~SERIAL_BIT_CLOCK_PIN_O;
            // sample one line while the other shifts
            if (lead_edge ^ cfg.pha) begin
              rsh_ff <= {rsh_ff[6:0], somi_s2_ff};
            end else begin
              SLAVE_IN_MASTER_OUT_LINE_O <= tsh_ff[7];
              tsh_ff <= tsh_ff << 1;
            end
            if (ei_ff == {cfg.len_m1, 1'b1}) begin
              mst_state_ff <= spimsp_pkg::SPIMSP_M_DONE;
            end
          end else begin
            hc_ff <= hc_ff + 8'h01;
          end
        end
        spimsp_pkg::SPIMSP_M_DONE: begin
          mst_state_ff <= spimsp_pkg::SPIMSP_M_IDLE;
        end
        default: begin
          mst_state_ff <= spimsp_pkg::SPIMSP_M_IDLE;
        end
      endcase
    end
  end

  // received characters into the fifo
  always_comb begin
    fifo_in_valid = 1'b0;
    fifo_in_data = rsh_ff;
    if (mst_state_ff == spimsp_pkg::SPIMSP_M_DONE) begin
      fifo_in_valid = 1'b1;
    end else if (slv_new && !cfg.master) begin
      fifo_in_valid = 1'b1;
      fifo_in_data = lrx_word_ff;
    end
  end

  spimsp_fifo #(
    .WIDTH(spimsp_pkg::CHAR_W),
    .DEPTH(spimsp_pkg::RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(rd_rb),
    .out_data(fifo_out_data)
  );

  // overrun: slave char lost on full fifo, set wins over clear
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      overrun_ff <= 1'b0;
    end else if (slv_new && !cfg.master && !fifo_in_ready) begin
      overrun_ff <= 1'b1;
    end else if (wr_st && REG_WDATA[spimsp_pkg::STS_OVR_BIT]) begin
      overrun_ff <= 1'b0;
    end
  end

  // read port, reserved addresses read zero
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      REG_RDATA <= 8'h00;
    end else if (!REG_RD) begin
      REG_RDATA <= 8'h00;
    end else if (REG_ADDR == spimsp_pkg::OFS_CONFIG_CONTROL) begin
      REG_RDATA <= config_control_ff;
    end else if (REG_ADDR == spimsp_pkg::OFS_OPERATION_CONTROL) begin
      REG_RDATA <= operation_control_ff;
    end else if (REG_ADDR == spimsp_pkg::OFS_PORT_STATUS) begin
      REG_RDATA <= 8'h00;
      REG_RDATA[spimsp_pkg::STS_RXAV_BIT] <= fifo_out_valid;
      REG_RDATA[spimsp_pkg::STS_BUSY_BIT] <= go_ff | (mst_state_ff != spimsp_pkg::SPIMSP_M_IDLE);
      REG_RDATA[spimsp_pkg::STS_OVR_BIT] <= overrun_ff;
      REG_RDATA[spimsp_pkg::STS_TXP_BIT] <= tx_pending;
    end else if (REG_ADDR == spimsp_pkg::OFS_BIT_RATE_DIVISOR) begin
      REG_RDATA <= bit_rate_divisor_ff;
    end else if (REG_ADDR == spimsp_pkg::OFS_RECEIVE_BUFFER) begin
      REG_RDATA <= fifo_out_valid ? fifo_out_data : 8'h00;
    end else if (REG_ADDR == spimsp_pkg::OFS_SHIFT_DATA) begin
      REG_RDATA <= shift_data_ff;
    end else if (REG_ADDR == spimsp_pkg::OFS_PIN_CONTROL_ONE) begin
      REG_RDATA <= pin_control_one_ff;
    end else if (REG_ADDR == spimsp_pkg::OFS_PIN_CONTROL_TWO) begin
      REG_RDATA <= pin_control_two_ff;
    end else if (REG_ADDR == spimsp_pkg::OFS_PRIORITY_CONTROL) begin
      REG_RDATA <= priority_control_ff;
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      SERIAL_BIT_CLOCK_PIN_OE_N <= 1'b1;
      SLAVE_IN_MASTER_OUT_LINE_OE_N <= 1'b1;
      SLAVE_OUT_MASTER_IN_LINE_OE_N <= 1'b1;
    end else begin
      SERIAL_BIT_CLOCK_PIN_OE_N <= ~cfg.master;
      SLAVE_IN_MASTER_OUT_LINE_OE_N <= ~cfg.master;
      SLAVE_OUT_MASTER_IN_LINE_OE_N <= ~(~cfg.master & (cfg.ste_fn ? ~ste_s2_ff : cfg.transmit_enable_bit));
    end
  end

  assign irq = cfg.int_en & (fifo_out_valid | overrun_ff);
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      INT_HIGH_LEVEL <= 1'b0;
      INT_LOW_LEVEL <= 1'b0;
    end else begin
      INT_HIGH_LEVEL <= irq & ~cfg.lvl_low;
      INT_LOW_LEVEL <= irq & cfg.lvl_low;
    end
  end

  // slave sample edge is rising edge of lclk
  assign lclk = SERIAL_BIT_CLOCK_PIN_I ^ (cfg.pol ^ cfg.pha);
  assign nxt_lrs = (lcnt_ff == 3'h0) ? {7'h00, SLAVE_IN_MASTER_OUT_LINE_I} : {lrs_ff[6:0], SLAVE_IN_MASTER_OUT_LINE_I};

  always_ff @(posedge lclk or posedge lclr_ff) begin
    if (lclr_ff) begin
      lcnt_ff <= 3'h0;
      lrs_ff <= 8'h00;
      lsh_ff <= 8'h00;
    end else begin
      lrs_ff <= nxt_lrs;
      lcnt_ff <= (lcnt_ff == cfg.len_m1) ? 3'h0 : lcnt_ff + 3'h1;
      if (lcnt_ff == 3'h0) begin
        lsh_ff <= spimsp_pkg::spimsp_align(lword_ff, cfg.len_m1) << 1;
      end else begin
        lsh_ff <= lsh_ff << 1;
      end
    end
  end

  always_ff @(posedge lclk or posedge lrst_ff) begin
    if (lrst_ff) begin
      lrx_word_ff <= 8'h00;
      lrx_tgl_ff <= 1'b0;
      ltx_s1_ff <= 1'b0;
      ltx_s2_ff <= 1'b0;
      lseen_ff <= 1'b0;
      lword_ff <= 8'h00;
    end else begin
      ltx_s1_ff <= tx_tgl_ff;
      ltx_s2_ff <= ltx_s1_ff;
      if (ltx_s2_ff != lseen_ff) begin
        lword_ff <= shift_data_ff;
        lseen_ff <= ltx_s2_ff;
      end
      if (!lclr_ff && lcnt_ff == cfg.len_m1) begin
        lrx_word_ff <= nxt_lrs;
        lrx_tgl_ff <= ~lrx_tgl_ff;
      end
    end
  end

  // slave output changes on the non-sampling edge
  always_ff @(negedge lclk or posedge lrst_ff) begin
    if (lrst_ff) begin
      lso_ff <= 1'b0;
    end else if (lcnt_ff == 3'h0) begin
      lso_ff <= lword_ff[cfg.len_m1];
    end else begin
      lso_ff <= lsh_ff[7];
    end
  end
  assign SLAVE_OUT_MASTER_IN_LINE_O = lso_ff;
endmodule : spimsp_top
`default_nettype wire

/* bench/spimsp_props.sv */
// checker for the serial port's register port and pin enables
// assumes it is bound onto spimsp_top and sees only its ports, one clock CLK_SYS
`timescale 1ns/100ps
`default_nettype none
module spimsp_props (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic [15:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic SERIAL_BIT_CLOCK_PIN_OE_N,
  input wire logic SLAVE_IN_MASTER_OUT_LINE_OE_N,
  input wire logic SLAVE_OUT_MASTER_IN_LINE_OE_N,
  input wire logic INT_HIGH_LEVEL,
  input wire logic INT_LOW_LEVEL
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  a_rdata_zero: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data not zero outside a read");
  a_rsv_read: assert property (REG_RD && REG_ADDR inside {16'h7043, 16'h7045, 16'h7046, 16'h7048,
    16'h704a, 16'h704b, 16'h704c} |=> REG_RDATA == 8'h00)
    else $error("reserved address read not zero");
  a_brr_back: assert property (REG_WR && REG_ADDR == 16'h7044 ##1 REG_RD && REG_ADDR == 16'h7044
    |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("divisor readback differs");
  a_ccr_back: assert property (REG_WR && REG_ADDR == 16'h7040 ##1 REG_RD && REG_ADDR == 16'h7040
    |=> (REG_RDATA & 8'h47) == ($past(REG_WDATA, 2) & 8'h47))
    else $error("config readback differs");
  a_reset_float: assert property ($rose(RESET_N) |-> SERIAL_BIT_CLOCK_PIN_OE_N
    && SLAVE_IN_MASTER_OUT_LINE_OE_N && SLAVE_OUT_MASTER_IN_LINE_OE_N)
    else $error("pin driven right after reset");
  a_int_excl: assert property (!(INT_HIGH_LEVEL && INT_LOW_LEVEL))
    else $error("both interrupt levels raised");
  a_oe_pair: assert property (SERIAL_BIT_CLOCK_PIN_OE_N == SLAVE_IN_MASTER_OUT_LINE_OE_N)
    else $error("clock and data out enables disagree");
  a_somi_master: assert property (!SERIAL_BIT_CLOCK_PIN_OE_N |-> SLAVE_OUT_MASTER_IN_LINE_OE_N)
    else $error("slave output driven in master mode");
endmodule : spimsp_props

bind spimsp_top spimsp_props u_spimsp_props (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .SERIAL_BIT_CLOCK_PIN_OE_N(SERIAL_BIT_CLOCK_PIN_OE_N), .SLAVE_IN_MASTER_OUT_LINE_OE_N(SLAVE_IN_MASTER_OUT_LINE_OE_N),
  .SLAVE_OUT_MASTER_IN_LINE_OE_N(SLAVE_OUT_MASTER_IN_LINE_OE_N), .INT_HIGH_LEVEL(INT_HIGH_LEVEL),
  .INT_LOW_LEVEL(INT_LOW_LEVEL));
`default_nettype wire

/* bench/spimsp_ext_master.sv */
// far-side serial master: link clock, data and slave enable; clock toggles in every xfer, with or without the enable
// assumes the bench resolves the slave output line and calls xfer at idle
`timescale 1ns/100ps
`default_nettype none
module spimsp_ext_master (
  output logic sclk,
  output logic mosi,
  output logic ste_n,
  input wire logic somi
);
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    ste_n = 1'b1;
  end
  // clock in frames, enable low, phase
  task automatic xfer(input logic [7:0] d, input int n, input logic pol, input logic pha, input logic sel,
                      output logic [7:0] r);
    int i;
    r = 8'h00;
    sclk = pol;
    #40;
    ste_n = ~sel;
    #100;
    for (i = n - 1; i >= 0; i--) begin
      if (!pha) mosi = d[i];
      #16;
      sclk = ~pol;
      if (pha) mosi = d[i];
      else r = {r[6:0], somi};
      #16;
      sclk = pol;
      if (pha) r = {r[6:0], somi};
    end
    #40;
    ste_n = 1'b1;
    // released line shows the inverse of its last level
    mosi = ~mosi;
  endtask : xfer
endmodule : spimsp_ext_master
`default_nettype wire

/* bench/tb_spimsp_top.sv */
// self-checking bench: registers, master loopback, slave frames, receive fifo
// assumes spimsp_ext_master as far master; in master mode the far slave echoes data out
`timescale 1ns/100ps
`default_nettype none
module tb_spimsp_top;
  logic clk;
  logic rst_n = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, r;
  logic sclk_o, sclk_oe_n, simo_o, simo_oe_n, somi_o, somi_oe_n, int_hi, int_lo, m_sclk, m_mosi, m_ste_n;
  wire sclk_w = sclk_oe_n ? m_sclk : sclk_o;
  wire simo_w = simo_oe_n ? m_mosi : simo_o;
  wire somi_w = somi_oe_n ? simo_w : somi_o;
  int failures = 0;
  int checked = 0;
  int toggles = 0;
  realtime t_wr = -1.0;
  realtime t_rd = -1.0;

  spimsp_top u_spimsp_top (.CLK_SYS(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WR(wr_en), .REG_RD(rd_en),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .SERIAL_BIT_CLOCK_PIN_I(sclk_w), .SERIAL_BIT_CLOCK_PIN_O(sclk_o),
    .SERIAL_BIT_CLOCK_PIN_OE_N(sclk_oe_n), .SLAVE_IN_MASTER_OUT_LINE_I(simo_w),
    .SLAVE_IN_MASTER_OUT_LINE_O(simo_o), .SLAVE_IN_MASTER_OUT_LINE_OE_N(simo_oe_n),
    .SLAVE_OUT_MASTER_IN_LINE_I(somi_w), .SLAVE_OUT_MASTER_IN_LINE_O(somi_o),
    .SLAVE_OUT_MASTER_IN_LINE_OE_N(somi_oe_n), .SLAVE_ENABLE_PIN_N(m_ste_n), .INT_HIGH_LEVEL(int_hi),
    .INT_LOW_LEVEL(int_lo));
  spimsp_ext_master u_spimsp_ext_master (.sclk(m_sclk), .mosi(m_mosi), .ste_n(m_ste_n),
    .somi(somi_oe_n ? 1'bx : somi_o));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(sclk_o) begin
    if (sclk_oe_n === 1'b0) toggles++;
  end

  task automatic summarize;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    if (t_wr == $realtime) @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    t_wr = $realtime;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    if (t_rd == $realtime) @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    d = rdata;
    t_rd = $realtime;
  endtask : rd

  task automatic rchk(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    logic [7:0] d;
    rd(a, d);
    chk(d & m, e);
  endtask : rchk

  task automatic sframe(input logic [7:0] tx, input logic pol, input logic pha, input logic sel,
                        input logic oe_exp, output logic [7:0] rx);
    fork
      u_spimsp_ext_master.xfer(tx, 8, pol, pha, sel, rx);
      begin
        #250;
        chk({7'h00, somi_oe_n}, {7'h00, oe_exp});
      end
    join
    repeat (9) @(negedge clk);
  endtask : sframe

  task automatic t_regs;
    rchk(16'h7040, 8'h07);
    rchk(16'h7041, 8'h00);
    rchk(16'h7044, 8'h03);
    rchk(16'h704d, 8'h00);
    rchk(16'h704f, 8'h00);
    wr(16'h7043, 8'hff);
    rchk(16'h7043, 8'h00);
    wr(16'h7044, 8'h05);
    rchk(16'h7044, 8'h05);
    wr(16'h7044, 8'h02);
  endtask : t_regs

  task automatic t_master;
    int i, n;
    logic [7:0] s;
    for (i = 0; i < 3; i++) begin
      n = (i == 0) ? 8 : (i == 1) ? 4 : 1;
      wr(16'h7040, 8'(n - 1));
      rchk(16'h7040, 8'(n - 1), 8'h47);
      wr(16'h704f, (i == 1) ? 8'h40 : 8'h00);
      wr(16'h7041, (i == 2) ? 8'h0d : 8'h05);
      toggles = 0;
      wr(16'h7049, 8'ha5);
      repeat (200) begin
        rd(16'h7042, s);
        if (s[0] === 1'b1) break;
      end
      chk(8'(toggles), 8'(2 * n));
      chk({6'h00, int_hi, int_lo}, (i == 1) ? 8'h01 : 8'h02);
      chk({6'h00, sclk_oe_n, somi_oe_n}, 8'h01);
      rchk(16'h7047, 8'ha5 & 8'((1 << n) - 1));
    end
  endtask : t_master

  task automatic t_slave;
    logic [7:0] m, tx, prv;
    // slave sends the word taken over during the previous frame
    prv = 8'h00;
    wr(16'h704d, 8'h01);
    for (m = 0; m < 4; m++) begin
      tx = 8'h3c ^ m;
      wr(16'h7040, {1'b0, m[1], 6'h07});
      wr(16'h7041, {4'h0, m[0], 3'b010});
      wr(16'h7049, tx);
      sframe(8'hc3 ^ m, m[1], m[0], 1'b1, 1'b0, r);
      rchk(16'h7047, 8'hc3 ^ m);
      chk(r & {m[0], 7'h7f}, prv & {m[0], 7'h7f});
      prv = tx;
    end
    sframe(8'h99, 1'b1, 1'b1, 1'b0, 1'b1, r);
    rchk(16'h7042, 8'h00, 8'h01);
  endtask : t_slave

  task automatic t_nofn;
    logic [7:0] k;
    wr(16'h704d, 8'h00);
    wr(16'h7041, 8'h08);
    for (k = 0; k < 17; k++) begin
      sframe(k, 1'b1, 1'b1, 1'b0, 1'b1, r);
    end
    rchk(16'h7042, 8'h05, 8'h05);
    wr(16'h7042, 8'h04);
    rchk(16'h7042, 8'h00, 8'h04);
    for (k = 0; k < 16; k++) begin
      rchk(16'h7047, k);
    end
    rchk(16'h7042, 8'h00, 8'h01);
  endtask : t_nofn

  initial begin
    #300000;
    failures++;
    summarize();
  end

  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_regs();
    t_master();
    t_slave();
    t_nofn();
    summarize();
  end
endmodule : tb_spimsp_top
`default_nettype wire
